// ==== verilog/wdtr_pkg.sv ====
package wdtr_pkg;
   localparam longint CLK_HZ      = 125_000_000;
   localparam longint RC_HZ       = 200_000;
   localparam longint XTAL_HZ     = 32_768;
   localparam int     RC_DIV      = int'((CLK_HZ + RC_HZ / 2) / RC_HZ);
   localparam int     XTAL_DIV    = int'((CLK_HZ + XTAL_HZ / 2) / XTAL_HZ);
   localparam longint T_BASE_RC_US  = 20_480;
   localparam longint T_BASE_XS_US  = 16_000;
   localparam longint T_BASE_XN_US  = 125_000;
   localparam int     BASE_RC_TICKS = int'(T_BASE_RC_US * RC_HZ / 1_000_000);
   localparam int     BASE_XS_TICKS = int'(T_BASE_XS_US * XTAL_HZ / 1_000_000);
   localparam int     BASE_XN_TICKS = int'(T_BASE_XN_US * XTAL_HZ / 1_000_000);
   localparam int     CNT_W       = 13;
   localparam int     PRE_W       = 11;
   localparam int     DIV_W       = 12;
   localparam logic [1:0] CK_XTAL = 2'h2;
   localparam logic [7:0] IDX_T0M = 8'h02;
   localparam logic [7:0] IDX_WDT = 8'h1e;
   localparam logic [7:0] IDX_IST = 8'h20;
   localparam logic [7:0] IDX_IMK = 8'h21;
   localparam int     FLAG_BIT    = 3;
   localparam logic [3:0] T0M_RST = 4'h0;
   localparam logic [1:0] IMK_RST = 2'h0;
   localparam int     EV_TMO      = 0;
   localparam int     EV_WAKE     = 1;

   function automatic logic [3:0] ratio_shift(input logic [2:0] sel,
                                              input logic       solar);
      logic [3:0] s;
      s = 4'h0;
      case (sel)
         3'h7: s = 4'h0;
         3'h6: s = 4'h1;
         3'h5: s = 4'h2;
         3'h4: s = 4'h3;
         3'h3: s = 4'h5;
         3'h2: s = solar ? 4'h5 : 4'h7;
         3'h1: s = solar ? 4'h5 : 4'h9;
         default: s = solar ? 4'h5 : 4'hb;
      endcase
      return s;
   endfunction : ratio_shift
endpackage : wdtr_pkg

// ==== verilog/wdtr_cnt_if.sv ====
`timescale 1ns/100ps
interface wdtr_cnt_if;
   logic                       tick;
   logic                       run;
   logic                       clear;
   logic [3:0]                 shift;
   logic [wdtr_pkg::CNT_W-1:0] base;
   logic [wdtr_pkg::CNT_W-1:0] cnt;
   logic                       ovf;
   modport ctl (output tick, output run, output clear, output shift,
                output base, input cnt, input ovf);
   modport cnt_side (input tick, input run, input clear, input shift,
                     input base, output cnt, output ovf);
endinterface : wdtr_cnt_if

// ==== verilog/wdtr_tick_gen.sv ====
`timescale 1ns/100ps
module wdtr_tick_gen #(
   parameter int RC_DIV   = wdtr_pkg::RC_DIV,
   parameter int XTAL_DIV = wdtr_pkg::XTAL_DIV
) (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   input  wire logic i_xtal,
   output logic      o_tick
);
   localparam logic [wdtr_pkg::DIV_W-1:0] RC_LAST = wdtr_pkg::DIV_W'(RC_DIV - 1);
   localparam logic [wdtr_pkg::DIV_W-1:0] XT_LAST = wdtr_pkg::DIV_W'(XTAL_DIV - 1);
   logic [wdtr_pkg::DIV_W-1:0] div_q;
   logic                       hit;

   // System clock rate chosen by the clock option
   assign hit = (div_q == (i_xtal ? XT_LAST : RC_LAST));

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         div_q  <= '0;
         o_tick <= 1'b0;
      end else begin
         div_q  <= hit ? '0 : div_q + 1'b1;
         o_tick <= hit;
      end
   end
endmodule : wdtr_tick_gen

// ==== verilog/wdtr_downcnt.sv ====
`timescale 1ns/100ps
module wdtr_downcnt (
   input  wire logic   i_ref_clk,
   input  wire logic   i_rst_n,
   wdtr_cnt_if.cnt_side cif
);
   logic [wdtr_pkg::PRE_W-1:0] pre_q;
   logic [wdtr_pkg::PRE_W-1:0] pre_last;
   logic                       step;

   // Ratio read live from the prescaler field
   assign pre_last = wdtr_pkg::PRE_W'((12'h001 << cif.shift) - 12'h001);
   assign step     = cif.run && cif.tick && (pre_q >= pre_last);

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || cif.clear) begin
         pre_q <= '0;
      end else if (cif.run && cif.tick) begin
         pre_q <= (pre_q >= pre_last) ? '0 : pre_q + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         cif.cnt <= '1;
         cif.ovf <= 1'b0;
      end else if (cif.clear) begin
         cif.cnt <= cif.base;
         cif.ovf <= 1'b0;
      end else if (step) begin
         cif.cnt <= (cif.cnt == '0) ? cif.base : cif.cnt - 1'b1;
         cif.ovf <= (cif.cnt == '0);
      end else begin
         cif.ovf <= 1'b0;
      end
   end
endmodule : wdtr_downcnt

// ==== verilog/wdtr_top.sv ====
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module wdtr_top #(
   parameter int RC_DIV        = wdtr_pkg::RC_DIV,
   parameter int XTAL_DIV      = wdtr_pkg::XTAL_DIV,
   parameter int BASE_RC_TICKS = wdtr_pkg::BASE_RC_TICKS,
   parameter int BASE_XS_TICKS = wdtr_pkg::BASE_XS_TICKS,
   parameter int BASE_XN_TICKS = wdtr_pkg::BASE_XN_TICKS
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic [31:0]      o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic [1:0]  i_opt_sys_clk,
   input  wire logic        i_opt_wdt_off,
   input  wire logic        i_opt_solar,
   input  wire logic        i_stop_mode,
   input  wire logic        i_stop_wake,
   input  wire logic        i_stop_int_wake,
   input  wire logic        i_pin_reset,
   output logic             o_dev_reset,
   output logic             o_prescale_sel_q,
   output logic             o_irq
);
   localparam logic [31:0] A_T0M = {22'h0, wdtr_pkg::IDX_T0M, 2'h0};
   localparam logic [31:0] A_WDT = {22'h0, wdtr_pkg::IDX_WDT, 2'h0};
   localparam logic [31:0] A_IST = {22'h0, wdtr_pkg::IDX_IST, 2'h0};
   localparam logic [31:0] A_IMK = {22'h0, wdtr_pkg::IDX_IMK, 2'h0};
   localparam logic [wdtr_pkg::CNT_W-1:0] B_RC =
      wdtr_pkg::CNT_W'(BASE_RC_TICKS - 1);
   localparam logic [wdtr_pkg::CNT_W-1:0] B_XS =
      wdtr_pkg::CNT_W'(BASE_XS_TICKS - 1);
   localparam logic [wdtr_pkg::CNT_W-1:0] B_XN =
      wdtr_pkg::CNT_W'(BASE_XN_TICKS - 1);

   // Option pin synchronisers, kept running through reset so the pins settle before capture
   logic [3:0] opt_s1_q;
   logic [3:0] opt_s2_q;
   logic [3:0] opt_q;
   logic       opt_ok_q;

   always_ff @(posedge i_ref_clk) begin
      opt_s1_q <= {i_opt_solar, i_opt_wdt_off, i_opt_sys_clk};
      opt_s2_q <= opt_s1_q;
   end

   // Options frozen once after reset release
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         opt_q    <= '0;
         opt_ok_q <= 1'b0;
      end else if (!opt_ok_q) begin
         opt_q    <= opt_s2_q;
         opt_ok_q <= 1'b1;
      end
   end

   logic xtal;
   logic wdt_en;
   logic solar;
   logic [3:0] opt_v;
   assign opt_v  = opt_ok_q ? opt_q : opt_s2_q;
   assign xtal   = (opt_v[1:0] == wdtr_pkg::CK_XTAL);
   assign wdt_en = opt_ok_q && !opt_q[2];
   assign solar  = opt_v[3];

   // AHB-Lite address phase capture
   logic        acc;
   logic        wr_q;
   logic [31:0] wa_q;
   assign acc = i_hsel && i_htrans[1] && i_hready;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         wr_q <= 1'b0;
         wa_q <= '0;
      end else begin
         wr_q <= acc && i_hwrite;
         wa_q <= i_haddr;
      end
   end

   logic wr_t0m;
   logic wr_wdt;
   logic wr_ist;
   logic wr_imk;
   assign wr_t0m = wr_q && (wa_q == A_T0M);
   assign wr_wdt = wr_q && (wa_q == A_WDT);
   assign wr_ist = wr_q && (wa_q == A_IST);
   assign wr_imk = wr_q && (wa_q == A_IMK);

   // Timer0 mode register, shared prescaler select
   logic [3:0] t0m_q;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         t0m_q <= wdtr_pkg::T0M_RST;
      end else if (wr_t0m) begin
         t0m_q <= i_hwdata[3:0];
      end
   end

   // Restart strobe: only a written one acts
   logic restart;
   assign restart = wr_wdt && i_hwdata[wdtr_pkg::FLAG_BIT];

   // Counter control
   wdtr_cnt_if cif ();
   logic tick;

   wdtr_tick_gen #(
      .RC_DIV   (RC_DIV),
      .XTAL_DIV (XTAL_DIV)
   ) u_tick (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_xtal    (xtal),
      .o_tick    (tick)
   );

   assign cif.tick  = tick;
   assign cif.run   = wdt_en && !i_stop_mode;
   assign cif.clear = restart || i_stop_wake || !opt_ok_q;
   assign cif.shift = wdtr_pkg::ratio_shift(t0m_q[2:0], solar);
   assign cif.base  = !xtal ? B_RC : (solar ? B_XS : B_XN);

   wdtr_downcnt u_cnt (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .cif       (cif.cnt_side)
   );

   // Device reset on overflow
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_dev_reset <= 1'b0;
      end else begin
         o_dev_reset <= cif.ovf && wdt_en;
      end
   end

   // Reset cause flag; setting events win over the time-out
   logic flag_q;
   logic flag_set;
   assign flag_set = i_pin_reset || i_stop_int_wake;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         flag_q <= 1'b1;
      end else if (flag_set) begin
         flag_q <= 1'b1;
      end else if (cif.ovf && wdt_en) begin
         flag_q <= 1'b0;
      end
   end

   // Interrupt status, mask and line
   logic [1:0] ev;
   logic [1:0] ist_q;
   logic [1:0] imk_q;
   assign ev = {i_stop_wake, cif.ovf && wdt_en};

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         ist_q <= '0;
      end else begin
         ist_q <= (ist_q & ~(wr_ist ? i_hwdata[1:0] : 2'h0)) | ev;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         imk_q <= wdtr_pkg::IMK_RST;
      end else if (wr_imk) begin
         imk_q <= i_hwdata[1:0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(ist_q & imk_q);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_prescale_sel_q <= 1'b0;
      end else begin
         o_prescale_sel_q <= solar;
      end
   end

   // Read data registered in the address phase
   function automatic logic [31:0] rd_mux(input logic [31:0] a);
      logic [31:0] d;
      d = '0;
      case (a)
         A_T0M:   d = {28'h0, t0m_q};
         A_WDT:   d = {28'h0, flag_q, 3'h0};
         A_IST:   d = {30'h0, ist_q};
         A_IMK:   d = {30'h0, imk_q};
         default: d = '0;
      endcase
      return d;
   endfunction : rd_mux

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_hrdata <= '0;
      end else if (acc && !i_hwrite) begin
         o_hrdata <= rd_mux(i_haddr);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_restart_wr;
      wr_wdt && i_hwdata[wdtr_pkg::FLAG_BIT];
   endsequence

   sequence s_zero_wr;
      wr_wdt && !i_hwdata[wdtr_pkg::FLAG_BIT] && !flag_set && !(cif.ovf && wdt_en);
   endsequence

   sequence s_timeout;
      cif.ovf && wdt_en && !flag_set;
   endsequence

   a_overflow_reset: assert property (cif.ovf && wdt_en |=> o_dev_reset)
      else $error("Overflow gave no device reset");
   a_flag_timeout: assert property (s_timeout |=> !flag_q)
      else $error("Flag not cleared by time-out");
   a_flag_keep: assert property (!(cif.ovf && wdt_en) |=> !$fell(flag_q))
      else $error("Flag cleared without time-out");
   a_flag_set: assert property (flag_set |=> flag_q)
      else $error("Flag not set by pin reset or wake");
   a_restart_load: assert property (s_restart_wr |=> cif.cnt == cif.base)
      else $error("Restart did not reload counter");
   a_zero_write: assert property (s_zero_wr ##0 !restart |=> $stable(flag_q))
      else $error("Writing zero changed the flag");
   a_stop_hold: assert property (i_stop_mode && !cif.clear |=> $stable(cif.cnt))
      else $error("Counter moved in STOP mode");
   a_wake_clear: assert property (i_stop_wake |=> cif.cnt == cif.base)
      else $error("Wake did not clear counter");
   a_disabled_quiet: assert property (opt_ok_q && opt_q[2] |-> ##1 !o_dev_reset)
      else $error("Disabled watchdog reset the device");
   a_irq_level: assert property (|(ist_q & imk_q) |=> o_irq)
      else $error("Interrupt line not raised");

   sequence s_step_live;
      u_cnt.step && !cif.clear;
   endsequence

   a_step_dec: assert property (s_step_live ##0 cif.cnt != '0 |=> cif.cnt == $past(cif.cnt) - 1'b1)
      else $error("Counter did not count down");
   a_ovf_reload: assert property (s_step_live ##0 cif.cnt == '0 |=> cif.ovf && cif.cnt == cif.base)
      else $error("Counter did not reload on overflow");
   a_ovf_cause: assert property (cif.ovf |-> $past(u_cnt.step) && $past(cif.cnt) == '0)
      else $error("Overflow without a step from zero");
   a_run_gate: assert property (!cif.run && !cif.clear |=> $stable(cif.cnt))
      else $error("Counter moved while not running");
   a_pre_restart: assert property (cif.clear |=> u_cnt.pre_q == '0)
      else $error("Prescaler not cleared on restart");
   a_clear_load: assert property (!opt_ok_q |=> cif.cnt == cif.base)
      else $error("Counter not loaded after power-on");
   a_opt_frozen: assert property (opt_ok_q |=> opt_ok_q && $stable(opt_q))
      else $error("Options changed after capture");
   a_run_on: assert property (opt_ok_q && !opt_q[2] && !i_stop_mode |-> cif.run)
      else $error("Enabled watchdog not running");
   a_off_idle: assert property (opt_ok_q && opt_q[2] |-> !cif.run)
      else $error("Disabled watchdog running");
   a_base_rc: assert property (opt_ok_q && opt_q[1:0] != wdtr_pkg::CK_XTAL |-> cif.base == B_RC)
      else $error("Wrong base period on RC clock");
   a_base_xtal: assert property (opt_ok_q && xtal |-> cif.base == (solar ? B_XS : B_XN))
      else $error("Wrong base period on crystal clock");
   a_ratio_one: assert property (t0m_q[2:0] == 3'h7 |-> cif.shift == 4'h0)
      else $error("Wrong prescaler ratio for code 7");
   a_ratio_two: assert property (t0m_q[2:0] == 3'h6 |-> cif.shift == 4'h1)
      else $error("Wrong prescaler ratio for code 6");
   a_ratio_four: assert property (t0m_q[2:0] == 3'h5 |-> cif.shift == 4'h2)
      else $error("Wrong prescaler ratio for code 5");
   a_ratio_eight: assert property (t0m_q[2:0] == 3'h4 |-> cif.shift == 4'h3)
      else $error("Wrong prescaler ratio for code 4");
   a_ratio_solar: assert property (solar && !t0m_q[2] |-> cif.shift == 4'h5)
      else $error("Wrong solar prescaler ratio");
   a_ratio_norm: assert property (!solar && t0m_q[2:0] == 3'h3 |-> cif.shift == 4'h5)
      else $error("Wrong prescaler ratio for code 3");
   a_ratio_mid: assert property (!solar && t0m_q[2:0] == 3'h2 |-> cif.shift == 4'h7)
      else $error("Wrong prescaler ratio for code 2");
   a_ratio_long: assert property (!solar && t0m_q[2:0] == 3'h1 |-> cif.shift == 4'h9)
      else $error("Wrong prescaler ratio for code 1");
   a_ratio_max: assert property (!solar && t0m_q[2:0] == 3'h0 |-> cif.shift == 4'hb)
      else $error("Wrong prescaler ratio for code 0");
   a_t0m_write: assert property (wr_t0m |=> t0m_q == $past(i_hwdata[3:0]))
      else $error("Timer0 mode write lost");
   a_t0m_hold: assert property (!wr_t0m |=> $stable(t0m_q))
      else $error("Timer0 mode changed without write");
   a_imk_write: assert property (wr_imk |=> imk_q == $past(i_hwdata[1:0]))
      else $error("Mask write lost");
   a_ist_set: assert property (cif.ovf && wdt_en |=> ist_q[0])
      else $error("Time-out status not set");
   a_ist_clear: assert property (wr_ist && i_hwdata[0] && !(cif.ovf && wdt_en) |=> !ist_q[0])
      else $error("Time-out status not cleared");
   a_wake_status: assert property (i_stop_wake |=> ist_q[1])
      else $error("Wake status not set");
   a_irq_low: assert property (!(|(ist_q & imk_q)) |=> !o_irq)
      else $error("Interrupt line raised without cause");
   a_read_flag: assert property (acc && !i_hwrite && i_haddr == A_WDT |=> o_hrdata[3] == $past(flag_q))
      else $error("Read of watchdog bit not the flag");
   a_zero_noclear: assert property (wr_wdt && !restart && !i_stop_wake && opt_ok_q |-> !cif.clear)
      else $error("Writing zero restarted the counter");
   a_bus_okay: assert property (o_hreadyout && !o_hresp)
      else $error("Bus response not ready and okay");
   a_dev_pulse: assert property (o_dev_reset |=> !o_dev_reset)
      else $error("Device reset longer than one cycle");
   a_dev_cause: assert property (o_dev_reset |-> $past(cif.ovf) && $past(wdt_en))
      else $error("Device reset without time-out");
   a_flag_rise: assert property (!flag_set |=> !$rose(flag_q))
      else $error("Flag set without pin reset or wake");
   a_tick_phase: assert property (cif.tick |-> u_tick.div_q == '0)
      else $error("Tick out of divider phase");
   a_sel_copy: assert property (1'b1 |=> o_prescale_sel_q == $past(solar))
      else $error("Solar option output wrong");
endmodule : wdtr_top

// ==== tb/wdtr_top_bench.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module wdtr_top_bench;
   localparam int RCD = 2;
   localparam int XD  = 3;
   localparam int BR  = 8;
   localparam int BS  = 4;
   localparam int BN  = 6;
   localparam int RN [8] = '{2048, 512, 128, 32, 8, 4, 2, 1};
   logic        clk, rst_n, hsel, hwrite, opt_off, opt_solar, stop, wake, iwake, pin;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, opt_ck;
   logic        hready, hresp, dev_rst, pre_q, irq;
   int          n_errors, checked, n, n_rst, n0;

   wdtr_top #(.RC_DIV(RCD), .XTAL_DIV(XD), .BASE_RC_TICKS(BR), .BASE_XS_TICKS(BS), .BASE_XN_TICKS(BN))
   wdtr_top_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(hresp), .i_opt_sys_clk(opt_ck), .i_opt_wdt_off(opt_off),
      .i_opt_solar(opt_solar), .i_stop_mode(stop), .i_stop_wake(wake), .i_stop_int_wake(iwake),
      .i_pin_reset(pin), .o_dev_reset(dev_rst), .o_prescale_sel_q(pre_q), .o_irq(irq));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      if (dev_rst === 1'b1) n_rst++;
   end

   task summarize;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   task tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick

   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      k = 0;
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
      do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
      do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 100);
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
      if (k >= 100) begin
         n_errors++;
         $display("mismatch hready exp 1 got 0");
         summarize();
      end
   endtask : bus

   task reset_dut(input logic [1:0] ck, input logic off, input logic sol);
      opt_ck <= ck; opt_off <= off; opt_solar <= sol; rst_n <= 1'b0;
      tick(4);
      rst_n <= 1'b1;
      tick(3);
   endtask : reset_dut

   task wait_rst(input int bound);
      n = 0;
      while (dev_rst !== 1'b1) begin
         @(posedge clk);
         n++;
         if (n > bound) begin
            n_errors++;
            $display("mismatch dev_reset exp 1 got 0");
            summarize();
         end
      end
   endtask : wait_rst

   task measure(input logic [2:0] sel, input int exp);
      bus(1'b1, 32'h08, {29'h0, sel});
      bus(1'b1, 32'h78, 32'h8);
      wait_rst(70000);
      tick(1);
      `CHK("reset pulse", 1'b0, dev_rst)
      wait_rst(70000);
      `CHK("period", 1'b1, (n + 1 >= exp - 2 && n + 1 <= exp + 2))
      tick(1);
   endtask : measure

   task t_regs;
      reset_dut(2'h0, 1'b0, 1'b0);
      bus(1'b0, 32'h78, 32'h0);
      `CHK("flag", 32'h8, rd)
      bus(1'b0, 32'h08, 32'h0);
      `CHK("t0m", 32'h0, rd)
      bus(1'b0, 32'h84, 32'h0);
      `CHK("mask", 32'h0, rd)
      bus(1'b1, 32'h40, 32'hf);
      bus(1'b0, 32'h40, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      $display("test regs done");
   endtask : t_regs

   task t_ratios;
      for (int s = 7; s >= 1; s--) begin
         measure(s[2:0], BR * RCD * RN[s]);
      end
      $display("test ratios done");
   endtask : t_ratios

   task t_options;
      reset_dut(2'h0, 1'b0, 1'b1);
      `CHK("solar", 1'b1, pre_q)
      measure(3'h7, BR * RCD);
      measure(3'h3, BR * RCD * 32);
      reset_dut(2'h2, 1'b0, 1'b1);
      measure(3'h7, BS * XD);
      measure(3'h4, BS * XD * 8);
      measure(3'h0, BS * XD * 32);
      reset_dut(2'h2, 1'b0, 1'b0);
      `CHK("solar", 1'b0, pre_q)
      measure(3'h7, BN * XD);
      measure(3'h3, BN * XD * 32);
      reset_dut(2'h1, 1'b0, 1'b0);
      measure(3'h7, BR * RCD);
      reset_dut(2'h3, 1'b0, 1'b0);
      measure(3'h7, BR * RCD);
      $display("test options done");
   endtask : t_options

   task t_flag;
      reset_dut(2'h0, 1'b0, 1'b0);
      bus(1'b1, 32'h08, 32'h6);
      wait_rst(200);
      tick(2);
      bus(1'b0, 32'h78, 32'h0);
      `CHK("flag", 32'h0, rd)
      bus(1'b1, 32'h78, 32'h0);
      bus(1'b0, 32'h78, 32'h0);
      `CHK("flag", 32'h0, rd)
      pin <= 1'b1;
      tick(1);
      pin <= 1'b0;
      bus(1'b0, 32'h78, 32'h0);
      `CHK("flag", 32'h8, rd)
      wait_rst(200);
      tick(2);
      iwake <= 1'b1;
      tick(1);
      iwake <= 1'b0;
      bus(1'b0, 32'h78, 32'h0);
      `CHK("flag", 32'h8, rd)
      $display("test flag done");
   endtask : t_flag

   task t_kick;
      bus(1'b1, 32'h08, 32'h7);
      bus(1'b1, 32'h78, 32'h8);
      n0 = n_rst;
      repeat (6) begin
         tick(6);
         bus(1'b1, 32'h78, 32'h8);
      end
      `CHK("kicked", n0, n_rst)
      repeat (3) begin
         tick(6);
         bus(1'b1, 32'h78, 32'h0);
      end
      `CHK("no kick", 1'b1, n_rst > n0)
      bus(1'b1, 32'h78, 32'h8);
      wait_rst(100);
      `CHK("restart", 1'b1, n >= BR * RCD - 4 && n <= BR * RCD + 2)
      tick(1);
      bus(1'b1, 32'h78, 32'h8);
      stop <= 1'b1;
      n0 = n_rst;
      tick(100);
      `CHK("stopped", n0, n_rst)
      wake <= 1'b1;
      tick(1);
      wake <= 1'b0;
      stop <= 1'b0;
      wait_rst(100);
      `CHK("wake", 1'b1, n >= BR * RCD - 4 && n <= BR * RCD + 2)
      tick(1);
      bus(1'b0, 32'h80, 32'h0);
      `CHK("wake status", 1'b1, rd[1])
      $display("test kick done");
   endtask : t_kick

   task t_irq;
      bus(1'b1, 32'h08, 32'h6);
      bus(1'b1, 32'h80, 32'h3);
      bus(1'b1, 32'h84, 32'h1);
      wait_rst(200);
      tick(2);
      `CHK("irq", 1'b1, irq)
      bus(1'b0, 32'h80, 32'h0);
      `CHK("status", 32'h1, rd)
      bus(1'b1, 32'h84, 32'h0);
      tick(2);
      `CHK("irq masked", 1'b0, irq)
      bus(1'b1, 32'h84, 32'h1);
      bus(1'b1, 32'h80, 32'h1);
      tick(2);
      `CHK("irq cleared", 1'b0, irq)
      $display("test irq done");
   endtask : t_irq

   task t_off;
      reset_dut(2'h0, 1'b1, 1'b0);
      bus(1'b1, 32'h08, 32'h7);
      n0 = n_rst;
      tick(300);
      `CHK("disabled", n0, n_rst)
      $display("test off done");
   endtask : t_off

   initial begin
      n_errors = 0; checked = 0; n_rst = 0;
      rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0;
      opt_ck = 2'h0; opt_off = 1'b0; opt_solar = 1'b0; stop = 1'b0; wake = 1'b0; iwake = 1'b0; pin = 1'b0;
      @(posedge clk);
      t_regs();
      t_ratios();
      t_options();
      t_flag();
      t_kick();
      t_irq();
      t_off();
      summarize();
   end
endmodule : wdtr_top_bench
